/* uart_command_enable_control_tb.sv */
`timescale 1ns/10ps
`include "ucec_defines.svh"

module uart_command_enable_control_tb;
	logic       mclk_i;
	logic       reset_n_i;
	logic       wr_en_i;
	logic       rd_en_i;
	logic       rxd_i;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic [7:0] rdata_o;
	logic [7:0] rd_val;
	logic       txd_o;
	logic       transmit_space_available_flag_o;
	logic       rxrdy_o;
	int         err_total;
	int         compares;
	logic [8:0] rows [6] = '{{8'hC0, 1'b1}, {8'h00, 1'b1}, {8'h20, 1'b1},
		{8'h80, 1'b0}, {8'h40, 1'b0}, {8'hC0, 1'b1}};

	always #10 mclk_i = ~mclk_i;

	ucec_top dut_u (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.addr_i    (addr_i),
		.wr_en_i   (wr_en_i),
		.rd_en_i   (rd_en_i),
		.wdata_i   (wdata_i),
		.rdata_o   (rdata_o),
		.rxd_i     (rxd_i),
		.txd_o     (txd_o),
		.transmit_space_available_flag_o   (transmit_space_available_flag_o),
		.rxrdy_o   (rxrdy_o)
	);

	ucec_line_peer peer_u (
		.mclk_i (mclk_i),
		.txd_i  (txd_o),
		.rxd_o  (rxd_i)
	);

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr_i = a;
		wdata_i = d;
		wr_en_i = 1'b1;
		@(negedge mclk_i);
		wr_en_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge mclk_i);
		addr_i = a;
		rd_en_i = 1'b1;
		@(negedge mclk_i);
		rd_en_i = 1'b0;
		@(negedge mclk_i);
		rd_val = rdata_o;
	endtask

	// bounded wait, under half a frame; send has already returned after the frame
	task automatic wait_rx;
		for (int n = 0; n < 2000 && rxrdy_o !== 1'b1; n++)
			@(negedge mclk_i);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge mclk_i);
		err_total++;
		results();
	end

	initial
	begin
		mclk_i = 1'b0;
		reset_n_i = 1'b0;
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		repeat (3) @(negedge mclk_i);
		reset_n_i = 1'b1;
		chk("txd idle", {7'h00, txd_o}, 8'h01);
		chk("transmit_space_available_flag reset", {7'h00, transmit_space_available_flag_o}, 8'h00);
		chk("rxrdy reset", {7'h00, rxrdy_o}, 8'h00);
		rd(`UCEC_CR_ADDR);
		chk("command readback", rd_val, 8'h00);
		rd(8'h20);
		chk("unmapped read", rd_val, 8'h00);
		$display("test reset done");

		foreach (rows[i])
		begin
			wr(`UCEC_CR_ADDR, rows[i][8:1]);
			repeat (2) @(negedge mclk_i);
			chk("transmit_space_available_flag pin", {7'h00, transmit_space_available_flag_o}, {7'h00, rows[i][0]});
			rd(`UCEC_SR_ADDR);
			chk("status tx space", {7'h00, rd_val[2]}, {7'h00, rows[i][0]});
			chk("status tx idle", {7'h00, rd_val[3]}, {7'h00, rows[i][0]});
		end
		$display("test enable rows done");

		peer_u.got.delete();
		wr(`UCEC_DATA_ADDR, 8'h5A);
		wr(`UCEC_DATA_ADDR, 8'hA5);
		wr(`UCEC_CR_ADDR, 8'h80);
		repeat (2) @(negedge mclk_i);
		chk("transmit_space_available_flag off", {7'h00, transmit_space_available_flag_o}, 8'h00);
		wr(`UCEC_DATA_ADDR, 8'h33);
		for (int n = 0; n < 30000 && peer_u.got.size() < 2; n++)
			@(negedge mclk_i);
		repeat (6000) @(negedge mclk_i);
		chk("tx count", 8'(peer_u.got.size()), 8'h02);
		chk("tx first", peer_u.got[0], 8'h5A);
		chk("tx second", peer_u.got[1], 8'hA5);
		$display("test tx drain done");

		wr(`UCEC_CR_ADDR, 8'hA0);
		peer_u.send(8'h3C, 1'b1);
		wait_rx();
		chk("rx first", {7'h00, rxrdy_o}, 8'h01);
		peer_u.send(8'h00, 1'b0);
		rd(`UCEC_SR_ADDR);
		chk("break framing", {4'h0, rd_val[7:4]}, 8'h0A);
		fork
			peer_u.send(8'h11, 1'b1);
		join_none
		repeat (2000) @(negedge mclk_i);
		wr(`UCEC_CR_ADDR, 8'h80);
		rd(`UCEC_SR_ADDR);
		chk("flags kept", {4'h0, rd_val[7:4]}, 8'h0A);
		chk("rx avail kept", {7'h00, rd_val[0]}, 8'h01);
		repeat (3000) @(negedge mclk_i);
		peer_u.send(8'h77, 1'b1);
		wr(`UCEC_CR_ADDR, 8'hA0);
		peer_u.send(8'h96, 1'b1);
		rd(`UCEC_DATA_ADDR);
		chk("rx head", rd_val, 8'h3C);
		rd(`UCEC_DATA_ADDR);
		chk("rx appended", rd_val, 8'h96);
		repeat (2) @(negedge mclk_i);
		chk("rx empty", {7'h00, rxrdy_o}, 8'h00);
		// host keeps bit 7 low for plain commands
		wr(`UCEC_CR_ADDR, `UCEC_CMD_RST_ERR);
		rd(`UCEC_SR_ADDR);
		chk("flags cleared", {4'h0, rd_val[7:4]}, 8'h00);
		$display("test rx enable done");

		wr(`UCEC_CR_ADDR, 8'h80);
		wr(`UCEC_MODE_ADDR, 8'h01);
		peer_u.send(8'h42, 1'b1);
		wait_rx();
		chk("wake rx", {7'h00, rxrdy_o}, 8'h01);
		wr(`UCEC_CR_ADDR, `UCEC_CMD_RST_RX);
		repeat (3) @(negedge mclk_i);
		chk("rx reset", {7'h00, rxrdy_o}, 8'h00);
		wr(`UCEC_MODE_ADDR, 8'h00);
		$display("test wake and rx reset done");

		wr(`UCEC_CR_ADDR, 8'hC0);
		peer_u.got.delete();
		wr(`UCEC_DATA_ADDR, 8'h01);
		wr(`UCEC_DATA_ADDR, 8'h02);
		wr(`UCEC_DATA_ADDR, 8'h03);
		wr(`UCEC_CR_ADDR, `UCEC_CMD_RST_TX);
		repeat (2) @(negedge mclk_i);
		chk("tx reset ready", {7'h00, transmit_space_available_flag_o}, 8'h00);
		repeat (9000) @(negedge mclk_i);
		chk("tx flushed", {7'h00, peer_u.got.size() > 1}, 8'h00);
		$display("test tx reset done");
		results();
	end
endmodule // uart_command_enable_control_tb

/* ucec_defines.svh */
`ifndef UCEC_DEFINES_SVH
`define UCEC_DEFINES_SVH

`define UCEC_CR_ADDR       8'h12
`define UCEC_SR_ADDR       8'h11
`define UCEC_DATA_ADDR     8'h14
`define UCEC_MODE_ADDR     8'h15

`define UCEC_CR_LOCK       7
`define UCEC_CR_TXEN       6
`define UCEC_CR_RXEN       5

`define UCEC_CMD_NONE      5'h00
`define UCEC_CMD_RST_RX    5'h02
`define UCEC_CMD_RST_TX    5'h03
`define UCEC_CMD_RST_ERR   5'h04

`define UCEC_SR_BRK        7
`define UCEC_SR_PE         6
`define UCEC_SR_FE         5
`define UCEC_SR_OV         4
`define UCEC_SR_TXIDLE     3
`define UCEC_SR_TRANSMIT_SPACE_AVAILABLE_FLAG      2
`define UCEC_SR_RXFULL     1
`define UCEC_SR_RXRDY      0

`define UCEC_MODE_WAKE     0
`define UCEC_MODE_PAR      1
`define UCEC_MODE_RESET    8'h00

`define UCEC_DATA_W        8
`define UCEC_FIFO_DEPTH    8
`define UCEC_CLK_HZ        50000000
`define UCEC_BAUD          115200
`define UCEC_DIV16         (`UCEC_CLK_HZ / (`UCEC_BAUD * 16))

`endif

/* ucec_line_peer.sv */
`timescale 1ns/10ps
`include "ucec_defines.svh"

module ucec_line_peer (
	input  wire logic mclk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	localparam int BIT = `UCEC_DIV16 * 16;
	logic [7:0] got [$];
	logic [7:0] cap;

	initial rxd_o = 1'b1;

	// start low, lsb first, then stop
	task automatic send(input logic [7:0] b, input logic stop_ok);
		rxd_o = 1'b0;
		repeat (BIT) @(negedge mclk_i);
		for (int i = 0; i < 8; i++)
		begin
			rxd_o = b[i];
			repeat (BIT) @(negedge mclk_i);
		end
		rxd_o = stop_ok;
		// bad stop cut short so no false start follows it
		repeat (stop_ok ? BIT : BIT * 6 / 10) @(negedge mclk_i);
		rxd_o = 1'b1;
		repeat (BIT) @(negedge mclk_i);
	endtask

	initial
	begin
		forever
		begin
			@(negedge txd_i);
			repeat (BIT / 2) @(negedge mclk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(negedge mclk_i);
				cap[i] = txd_i;
			end
			repeat (BIT) @(negedge mclk_i);
			got.push_back(cap);
		end
	end
endmodule // ucec_line_peer

/* ucec_pkg.sv */
package ucec_pkg;
	typedef enum logic [1:0] {
		UCEC_RX_IDLE  = 2'b00,
		UCEC_RX_START = 2'b01,
		UCEC_RX_DATA  = 2'b10,
		UCEC_RX_STOP  = 2'b11
	} ucec_rx_state_t;

	typedef enum logic [0:0] {
		UCEC_TX_IDLE  = 1'b0,
		UCEC_TX_SHIFT = 1'b1
	} ucec_tx_state_t;
endpackage

/* ucec_top.sv */
`timescale 1ns/10ps
`include "ucec_defines.svh"

module ucec_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	wire           push = in_valid_i & in_ready_o;
	wire           pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (cnt_r != D[AW:0]);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];

	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem_r[wp_r] <= in_data_i;
	end

	// reset and flush are the only paths that rewind pointers
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i || flush_i)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // ucec_fifo

module ucec_top (
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	input  wire logic [7:0] wdata_i,
	output logic [7:0]      rdata_o,
	input  wire logic       rxd_i,
	output logic            txd_o,
	output logic            transmit_space_available_flag_o,
	output logic            rxrdy_o
);
	import ucec_pkg::*;

	ucec_pkg::ucec_rx_state_t rx_state_r;
	ucec_pkg::ucec_tx_state_t tx_state_r;
	logic       tx_en_r;
	logic       rx_en_r;
	logic [7:0] mode_r;
	logic       brk_r;
	logic       pe_r;
	logic       fe_r;
	logic       ov_r;
	logic       rxd_m_r;
	logic       rxd_s_r;
	logic [7:0] div_r;
	logic [3:0] rx_ph_r;
	logic [3:0] rx_bit_r;
	logic [8:0] rx_sr_r;
	logic       rx_push_r;
	logic [7:0] rx_push_data_r;
	logic [3:0] tx_ph_r;
	logic [3:0] tx_bit_r;
	logic [10:0] tx_sr_r;

	// command register decode, all fields from one write
	wire       cr_wr     = wr_en_i && (addr_i == `UCEC_CR_ADDR);
	wire [4:0] cr_cmd    = wdata_i[4:0];
	wire       cr_upd    = cr_wr && wdata_i[`UCEC_CR_LOCK];
	wire       cmd_rstrx = cr_wr && (cr_cmd == `UCEC_CMD_RST_RX);
	wire       cmd_rsttx = cr_wr && (cr_cmd == `UCEC_CMD_RST_TX);
	wire       cmd_rsterr = cr_wr && (cr_cmd == `UCEC_CMD_RST_ERR);
	wire       mode_wr   = wr_en_i && (addr_i == `UCEC_MODE_ADDR);
	wire       data_wr   = wr_en_i && (addr_i == `UCEC_DATA_ADDR);
	wire       data_rd   = rd_en_i && (addr_i == `UCEC_DATA_ADDR);
	wire       par_en    = mode_r[`UCEC_MODE_PAR];
	wire       wake_en   = mode_r[`UCEC_MODE_WAKE];
	wire       rx_active = rx_en_r || wake_en;
	wire       tick16    = (div_r == 8'(`UCEC_DIV16 - 1));

	wire       txq_in_ready;
	wire       txq_out_valid;
	wire [7:0] txq_out_data;
	wire       rxq_in_ready;
	wire       rxq_out_valid;
	wire [7:0] rxq_out_data;
	wire       rxq_full = !rxq_in_ready;
	// host pushes only while enabled; the queue drains regardless
	wire       txq_push = data_wr && tx_en_r;
	wire       tx_load  = (tx_state_r == UCEC_TX_IDLE) && txq_out_valid;
	wire       tx_idle  = tx_en_r && (tx_state_r == UCEC_TX_IDLE) && !txq_out_valid;
	wire       transmit_space_available_flag    = tx_en_r && txq_in_ready;
	wire [3:0] tx_last  = par_en ? 4'hA : 4'h9;
	wire       tx_par   = ^txq_out_data;

	wire [3:0] rx_last  = par_en ? 4'h8 : 4'h7;
	wire [7:0] rx_data  = par_en ? rx_sr_r[7:0] : rx_sr_r[8:1];
	wire       rx_stop_ev = (rx_state_r == UCEC_RX_STOP) && tick16 && (rx_ph_r == 4'hF);
	wire       fe_set   = rx_stop_ev && !rxd_s_r;
	wire       brk_set  = fe_set && (rx_data == 8'h00);
	wire       pe_set   = rx_stop_ev && par_en && (^rx_sr_r);
	wire       ov_set   = rx_push_r && rxq_full;

	wire [7:0] status_w = {brk_r, pe_r, fe_r, ov_r, tx_idle, transmit_space_available_flag, rxq_full, rxq_out_valid};
	wire [7:0] rd_mux   = (addr_i == `UCEC_SR_ADDR)   ? status_w :
	                      (addr_i == `UCEC_DATA_ADDR) ? rxq_out_data :
	                      (addr_i == `UCEC_MODE_ADDR) ? mode_r : 8'h00;

	ucec_fifo #(.W(`UCEC_DATA_W), .D(`UCEC_FIFO_DEPTH)) u_txq (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (cmd_rsttx),
		.in_valid_i  (txq_push),
		.in_ready_o  (txq_in_ready),
		.in_data_i   (wdata_i),
		.out_valid_o (txq_out_valid),
		.out_ready_i (tx_load),
		.out_data_o  (txq_out_data)
	);

	// only the reset command flushes; disable leaves queued data alone
	ucec_fifo #(.W(`UCEC_DATA_W), .D(`UCEC_FIFO_DEPTH)) u_rxq (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (cmd_rstrx),
		.in_valid_i  (rx_push_r),
		.in_ready_o  (rxq_in_ready),
		.in_data_i   (rx_push_data_r),
		.out_valid_o (rxq_out_valid),
		.out_ready_i (data_rd),
		.out_data_o  (rxq_out_data)
	);

	// reset command clears enable, a same-write update then wins
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			tx_en_r <= 1'b0;
			rx_en_r <= 1'b0;
		end
		else if (cr_upd)
		begin
			tx_en_r <= wdata_i[`UCEC_CR_TXEN];
			rx_en_r <= wdata_i[`UCEC_CR_RXEN];
		end
		else
		begin
			tx_en_r <= tx_en_r && !cmd_rsttx;
			rx_en_r <= rx_en_r && !cmd_rstrx;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			mode_r <= `UCEC_MODE_RESET;
		else if (mode_wr)
			mode_r <= wdata_i;
	end

	// set wins over clear; rx disable touches none of these
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			brk_r <= 1'b0;
			pe_r  <= 1'b0;
			fe_r  <= 1'b0;
			ov_r  <= 1'b0;
		end
		else
		begin
			brk_r <= (brk_r && !(cmd_rsterr || cmd_rstrx)) || brk_set;
			pe_r  <= (pe_r  && !(cmd_rsterr || cmd_rstrx)) || pe_set;
			fe_r  <= (fe_r  && !(cmd_rsterr || cmd_rstrx)) || fe_set;
			ov_r  <= (ov_r  && !(cmd_rsterr || cmd_rstrx)) || ov_set;
		end
	end

	// pin synchroniser and 16x bit clock enable
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			rxd_m_r <= 1'b1;
			rxd_s_r <= 1'b1;
			div_r   <= 8'h00;
		end
		else
		begin
			rxd_m_r <= rxd_i;
			rxd_s_r <= rxd_m_r;
			div_r   <= tick16 ? 8'h00 : div_r + 8'h01;
		end
	end

	// receiver: a disable abort leaves queue and flags as they are; the rx reset command clears both
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i || !rx_active || cmd_rstrx)
		begin
			rx_state_r <= UCEC_RX_IDLE;
			rx_ph_r    <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_push_r  <= 1'b0;
		end
		else
		begin
			rx_push_r <= rx_stop_ev && !fe_set;
			case (rx_state_r)
				UCEC_RX_IDLE:
				begin
					rx_ph_r <= 4'h0;
					if (!rxd_s_r)
						rx_state_r <= UCEC_RX_START;
				end
				UCEC_RX_START:
					if (tick16)
					begin
						rx_ph_r <= rx_ph_r + 4'h1;
						if (rx_ph_r == 4'h7)
						begin
							rx_ph_r    <= 4'h0;
							rx_bit_r   <= 4'h0;
							// mid-bit recheck filters glitches
							rx_state_r <= rxd_s_r ? UCEC_RX_IDLE : UCEC_RX_DATA;
						end
					end
				UCEC_RX_DATA:
					if (tick16)
					begin
						rx_ph_r <= rx_ph_r + 4'h1;
						if (rx_ph_r == 4'hF)
						begin
							rx_bit_r <= rx_bit_r + 4'h1;
							if (rx_bit_r == rx_last)
								rx_state_r <= UCEC_RX_STOP;
						end
					end
				UCEC_RX_STOP:
					if (tick16)
					begin
						rx_ph_r <= rx_ph_r + 4'h1;
						if (rx_ph_r == 4'hF)
							rx_state_r <= UCEC_RX_IDLE;
					end
				default:
					rx_state_r <= UCEC_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			rx_sr_r        <= 9'h000;
			rx_push_data_r <= 8'h00;
		end
		else
		begin
			if (rx_state_r == UCEC_RX_DATA && tick16 && rx_ph_r == 4'hF)
				rx_sr_r <= {rxd_s_r, rx_sr_r[8:1]};
			if (rx_stop_ev)
				rx_push_data_r <= rx_data;
		end
	end

	// transmitter: frame is start, data lsb first, optional even parity, stop
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i || cmd_rsttx)
		begin
			tx_state_r <= UCEC_TX_IDLE;
			tx_sr_r    <= 11'h7FF;
			tx_ph_r    <= 4'h0;
			tx_bit_r   <= 4'h0;
		end
		else
		begin
			case (tx_state_r)
				UCEC_TX_IDLE:
					if (tx_load)
					begin
						tx_sr_r    <= par_en ? {1'b1, tx_par, txq_out_data, 1'b0}
						                     : {2'b11, txq_out_data, 1'b0};
						tx_ph_r    <= 4'h0;
						tx_bit_r   <= 4'h0;
						tx_state_r <= UCEC_TX_SHIFT;
					end
				UCEC_TX_SHIFT:
					if (tick16)
					begin
						tx_ph_r <= tx_ph_r + 4'h1;
						if (tx_ph_r == 4'hF)
						begin
							tx_sr_r  <= {1'b1, tx_sr_r[10:1]};
							tx_bit_r <= tx_bit_r + 4'h1;
							if (tx_bit_r == tx_last)
								tx_state_r <= UCEC_TX_IDLE;
						end
					end
				default:
					tx_state_r <= UCEC_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			txd_o   <= 1'b1;
			transmit_space_available_flag_o <= 1'b0;
			rxrdy_o <= 1'b0;
			rdata_o <= 8'h00;
		end
		else
		begin
			txd_o   <= (tx_state_r == UCEC_TX_SHIFT) ? tx_sr_r[0] : 1'b1;
			transmit_space_available_flag_o <= transmit_space_available_flag;
			rxrdy_o <= rxq_out_valid;
			rdata_o <= rd_en_i ? rd_mux : rdata_o;
		end
	end

	sequence cr_write_s(bit lk);
		cr_wr && (wdata_i[`UCEC_CR_LOCK] == lk);
	endsequence

	cr_lock_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b0) and (!cmd_rstrx && !cmd_rsttx)
		|=> $stable(tx_en_r) && $stable(rx_en_r))
		else $error("enables changed on locked command write");

	cr_update_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b1) |=> tx_en_r == $past(wdata_i[6]) && rx_en_r == $past(wdata_i[5]))
		else $error("enables not loaded from command write");

	tx_ready_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b1) and (wdata_i[6] && txq_in_ready && !cmd_rsttx && !data_wr)
		|-> ##2 transmit_space_available_flag_o)
		else $error("transmit space flag not raised after enable");

	tx_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b1) and (!wdata_i[6]) |-> ##1 !tx_idle ##1 !transmit_space_available_flag_o)
		else $error("transmit flags still set after disable");

	tx_drain_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!tx_en_r && txq_out_valid && tx_state_r == UCEC_TX_IDLE && !cmd_rsttx
		|=> tx_state_r == UCEC_TX_SHIFT)
		else $error("disabled transmitter did not drain queue");

	rx_hunt_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		rx_active && rx_state_r == UCEC_RX_IDLE && !rxd_s_r && !cmd_rstrx
		&& !(cr_upd && !wdata_i[5]) |=> rx_state_r == UCEC_RX_START)
		else $error("receiver missed start bit");

	rx_stop_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!rx_en_r && !wake_en |=> rx_state_r == UCEC_RX_IDLE && !rx_push_r)
		else $error("disabled receiver still running");

	rx_flags_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b1) and (!wdata_i[5] && cr_cmd != `UCEC_CMD_RST_RX
		&& cr_cmd != `UCEC_CMD_RST_ERR)
		|=> !$fell(fe_r) && !$fell(ov_r) && !$fell(pe_r) && !$fell(brk_r))
		else $error("receiver disable altered status flags");

	rx_keep_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cr_write_s(1'b1) and (rxq_out_valid && !wdata_i[5] && cr_cmd != `UCEC_CMD_RST_RX
		&& !data_rd) |=> rxq_out_valid)
		else $error("receive queue lost data on disable");

	wake_run_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		wake_en && !rx_en_r && rx_state_r == UCEC_RX_IDLE && !rxd_s_r && !cmd_rstrx
		&& !mode_wr |=> rx_state_r == UCEC_RX_START)
		else $error("wake-up receiver stopped while disabled");

	rxq_flush_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cmd_rstrx |=> !rxq_out_valid && rx_state_r == UCEC_RX_IDLE)
		else $error("receiver reset left data queued");

	txq_flush_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cmd_rsttx |=> !txq_out_valid && tx_state_r == UCEC_TX_IDLE)
		else $error("transmitter reset left data queued");

	err_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		cmd_rsterr && !fe_set && !pe_set && !ov_set |=> status_w[7:4] == 4'h0)
		else $error("error flags not cleared by command");
endmodule // ucec_top
